// File: hw/drt_top.sv
// Operation
// - Idle timer: free 16-bit down-counter, hidden
// - Bit 12 toggle sets idle tick pending
// - Idle tick interrupt gated by its enable
// - 16-bit main timer, registers A, B, pins
// - Setting 101 toggles pin A on underflow
// - Pulse mode reloads A first, then B, A
// - Reload source sets matching sticky pending flag
// - Enables A and B gate their interrupts
// - Run flag starts and stops pulse/event modes
// - Event mode counts selected pin A edges
// - Event underflow sets pending A
// - Event mode pin B rise sets pending B
// - Event mode never drives pin A
// - Capture mode copies count on pin edges
// - Capture edges chosen per pin
// - Capture sets pending A or B
// - Capture underflow sets run flag, irq A
// - Reset clears counters, registers, pending and run flags
module drt_top (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire drt_pkg::drt_ctrl_s ctrl_i,
   input wire drt_pkg::drt_cmd_s cmd_i,
   input wire logic [15:0] wdata_i,
   input wire logic timer_pin_a_i,
   input wire logic timer_pin_b_i,
   output logic timer_pin_a_o,
   output logic timer_pin_a_oe_o,
   output logic [15:0] main_timer_o,
   output logic [15:0] reload_capture_reg_a_o,
   output logic [15:0] reload_capture_reg_b_o,
   output drt_pkg::drt_stat_s status_o,
   output logic irq_a_o,
   output logic irq_b_o,
   output logic idle_irq_o
);
   // Reset synchroniser stages
   logic rst_meta_n;
   logic rst_n;
   // Instruction cycle strobe
   logic tick;
   // Pin edges
   logic pin_a_rise;
   logic pin_a_fall;
   logic pin_b_rise;
   logic pin_b_fall;
   // Hidden idle counter
   logic [15:0] idle_tick_timer;
   // Main counter and its two registers
   logic [15:0] main_timer;
   logic [15:0] reload_capture_reg_a;
   logic [15:0] reload_capture_reg_b;
   // Software visible flags
   logic main_pending_a;
   logic main_pending_b;
   logic idle_tick_pending;
   logic main_run_or_underflow_flag;
   // Pulse mode: next reload comes from B
   logic reload_from_b;
   // Run flag of the previous cycle, to restart the sequence
   logic run_prev;
   // Decoded mode classes
   logic mode_pwm;
   logic mode_evt;
   logic mode_cap;
   logic pwm_toggle;
   // Counting strobe and underflow for this cycle
   logic count_en;
   logic underflow;
   logic idle_toggle;
   // Capture and event triggers
   logic cap_a;
   logic cap_b;
   logic evt_edge;
   // Next values
   logic [15:0] next_main_timer;
   logic [15:0] next_idle_tick_timer;

   // Pick the rising or the falling edge of a pin
   function automatic logic pick_edge(input logic rise, input logic fall,
                                      input logic use_fall);
      pick_edge = use_fall ? fall : rise;
   endfunction : pick_edge

   // One step down, wrapping from zero to full scale
   function automatic logic [15:0] dec16(input logic [15:0] val);
      dec16 = val - drt_pkg::TIMER_ONE;
   endfunction : dec16

   // Release reset through two flip-flops
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   // Instruction cycle divider
   drt_tick u_tick (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .tick_o(tick)
   );

   // Edge finder for pin A
   drt_edge u_edge_a (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .level_i(timer_pin_a_i),
      .rise_o(pin_a_rise),
      .fall_o(pin_a_fall)
   );

   // Edge finder for pin B
   drt_edge u_edge_b (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .level_i(timer_pin_b_i),
      .rise_o(pin_b_rise),
      .fall_o(pin_b_fall)
   );

   // Mode decode
   always_comb begin
      mode_pwm = 1'b0;
      mode_evt = 1'b0;
      mode_cap = 1'b0;
      pwm_toggle = 1'b0;
      case (ctrl_i.mode)
         // Pulse generation, pin A toggles
         drt_pkg::MODE_PWM_TOGGLE: begin
            mode_pwm = 1'b1;
            pwm_toggle = 1'b1;
         end
         // Pulse generation, pin A holds
         drt_pkg::MODE_PWM_HOLD: begin
            mode_pwm = 1'b1;
         end
         // External event counting
         drt_pkg::MODE_EVT_RISE, drt_pkg::MODE_EVT_FALL: begin
            mode_evt = 1'b1;
         end
         // All four capture settings
         drt_pkg::MODE_CAP_RR, drt_pkg::MODE_CAP_FR,
         drt_pkg::MODE_CAP_RF, drt_pkg::MODE_CAP_FF: begin
            mode_cap = 1'b1;
         end
         // Unreachable with a 3-bit field
         default: begin
            mode_cap = 1'b0;
         end
      endcase
   end

   // Event mode edge: bit1 picks the falling edge of pin A
   assign evt_edge = pick_edge(pin_a_rise, pin_a_fall,
                               ctrl_i.mode[drt_pkg::MSEL_BIT1]);

   // Capture triggers: bit1 selects pin A fall, bit3 pin B fall
   assign cap_a = mode_cap & pick_edge(pin_a_rise, pin_a_fall,
                  ctrl_i.mode[drt_pkg::MSEL_BIT1]);
   assign cap_b = mode_cap & pick_edge(pin_b_rise, pin_b_fall,
                  ctrl_i.mode[drt_pkg::MSEL_BIT3]);

   // Counting strobe per mode
   always_comb begin
      count_en = 1'b0;
      if (mode_pwm) begin
         count_en = tick & main_run_or_underflow_flag;
      end else if (mode_evt) begin
         count_en = evt_edge & main_run_or_underflow_flag;
      end else begin
         count_en = tick;
      end
   end

   // Underflow is a count step taken at zero
   assign underflow = count_en & (main_timer == drt_pkg::TIMER_ZERO);

   // Next main count: reload, wrap or step
   always_comb begin
      next_main_timer = main_timer;
      if (cmd_i.wr_timer) begin
         next_main_timer = wdata_i;
      end else if (count_en) begin
         if (underflow && mode_pwm) begin
            // Alternate reload source
            next_main_timer = reload_from_b ? reload_capture_reg_b
                                            : reload_capture_reg_a;
         end else if (underflow && mode_evt) begin
            next_main_timer = reload_capture_reg_a;
         end else begin
            next_main_timer = dec16(main_timer);
         end
      end
   end

   // Main counter register
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         main_timer <= drt_pkg::TIMER_RST;
      end else begin
         main_timer <= next_main_timer;
      end
   end

   // Reload order: first underflow after start takes A
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         reload_from_b <= drt_pkg::FLAG_RST;
         run_prev <= drt_pkg::FLAG_RST;
      end else begin
         run_prev <= main_run_or_underflow_flag;
         if (!mode_pwm || (main_run_or_underflow_flag && !run_prev)) begin
            // Restart the sequence on entry or start
            reload_from_b <= 1'b0;
         end else if (underflow) begin
            reload_from_b <= ~reload_from_b;
         end
      end
   end

   // Register A: software load or capture, capture wins
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         reload_capture_reg_a <= drt_pkg::TIMER_RST;
      end else if (cap_a) begin
         reload_capture_reg_a <= main_timer;
      end else if (cmd_i.wr_a) begin
         reload_capture_reg_a <= wdata_i;
      end
   end

   // Register B: software load or capture, capture wins
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         reload_capture_reg_b <= drt_pkg::TIMER_RST;
      end else if (cap_b) begin
         reload_capture_reg_b <= main_timer;
      end else if (cmd_i.wr_b) begin
         reload_capture_reg_b <= wdata_i;
      end
   end

   // Pending A: set by its source in each mode, set beats clear
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         main_pending_a <= drt_pkg::FLAG_RST;
      end else if (mode_pwm && underflow && !reload_from_b) begin
         main_pending_a <= 1'b1;
      end else if (mode_evt && underflow) begin
         main_pending_a <= 1'b1;
      end else if (cap_a) begin
         main_pending_a <= 1'b1;
      end else if (cmd_i.clr_pend_a) begin
         main_pending_a <= 1'b0;
      end
   end

   // Pending B: set by its source in each mode, set beats clear
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         main_pending_b <= drt_pkg::FLAG_RST;
      end else if (mode_pwm && underflow && reload_from_b) begin
         main_pending_b <= 1'b1;
      end else if (mode_evt && pin_b_rise) begin
         main_pending_b <= 1'b1;
      end else if (cap_b) begin
         main_pending_b <= 1'b1;
      end else if (cmd_i.clr_pend_b) begin
         main_pending_b <= 1'b0;
      end
   end

   // Run flag, doubling as underflow pending in capture
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         main_run_or_underflow_flag <= drt_pkg::FLAG_RST;
      end else if (mode_cap && underflow) begin
         main_run_or_underflow_flag <= 1'b1;
      end else if (cmd_i.run_set) begin
         main_run_or_underflow_flag <= 1'b1;
      end else if (cmd_i.run_clr) begin
         main_run_or_underflow_flag <= 1'b0;
      end
   end

   // Idle timer steps down each instruction cycle
   always_comb begin
      next_idle_tick_timer = idle_tick_timer;
      if (tick) begin
         next_idle_tick_timer = dec16(idle_tick_timer);
      end
   end

   // Tick bit changed on this step
   assign idle_toggle = next_idle_tick_timer[drt_pkg::IDLE_TICK_BIT] ^
                        idle_tick_timer[drt_pkg::IDLE_TICK_BIT];

   // Idle counter register, no software access
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         idle_tick_timer <= drt_pkg::TIMER_RST;
      end else begin
         idle_tick_timer <= next_idle_tick_timer;
      end
   end

   // Idle tick pending, set beats clear
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         idle_tick_pending <= drt_pkg::FLAG_RST;
      end else if (idle_toggle) begin
         idle_tick_pending <= 1'b1;
      end else if (cmd_i.clr_idle_pend) begin
         idle_tick_pending <= 1'b0;
      end
   end

   // Pin A: driven only in pulse mode, toggled on underflow in setting 101
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         timer_pin_a_o <= drt_pkg::FLAG_RST;
         timer_pin_a_oe_o <= drt_pkg::FLAG_RST;
      end else begin
         timer_pin_a_oe_o <= mode_pwm;
         if (pwm_toggle && underflow) begin
            timer_pin_a_o <= ~timer_pin_a_o;
         end
      end
   end

   // Interrupt requests, registered
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_a_o <= drt_pkg::FLAG_RST;
         irq_b_o <= drt_pkg::FLAG_RST;
         idle_irq_o <= drt_pkg::FLAG_RST;
      end else begin
         // Capture underflow shares interrupt A
         irq_a_o <= ctrl_i.irq_en_a & (main_pending_a |
                    (mode_cap & main_run_or_underflow_flag));
         irq_b_o <= ctrl_i.irq_en_b & main_pending_b;
         idle_irq_o <= ctrl_i.idle_en & idle_tick_pending;
      end
   end

   // Software views of counter, registers and flags
   assign main_timer_o = main_timer;
   assign reload_capture_reg_a_o = reload_capture_reg_a;
   assign reload_capture_reg_b_o = reload_capture_reg_b;
   assign status_o = '{pend_a: main_pending_a,
                       pend_b: main_pending_b,
                       idle_pend: idle_tick_pending,
                       run_flag: main_run_or_underflow_flag};
endmodule : drt_top

// File: hw/drt_pkg.sv
package drt_pkg;
   // Counter width of both timers
   localparam int TIMER_W = 16;
   // System clock period and instruction cycle period
   localparam int CLK_PERIOD_NS = 25;
   localparam int TC_PERIOD_NS = 1000;
   // System clocks per instruction cycle
   localparam int TC_CYCLES = TC_PERIOD_NS / CLK_PERIOD_NS;
   // Width of the instruction cycle divider
   localparam int TC_CNT_W = 6;
   // Idle timer bit whose toggle raises the tick
   localparam int IDLE_TICK_BIT = 12;
   // Mode select field positions (bit3, bit2, bit1)
   localparam int MSEL_BIT3 = 2;
   localparam int MSEL_BIT2 = 1;
   localparam int MSEL_BIT1 = 0;
   // Reset and wrap values
   localparam logic [15:0] TIMER_RST = 16'h0000;
   localparam logic [15:0] TIMER_ZERO = 16'h0000;
   localparam logic [15:0] TIMER_ONE = 16'h0001;
   localparam logic [15:0] TIMER_FULL = 16'hffff;
   localparam logic [5:0] TC_CNT_RST = 6'h00;
   localparam logic [5:0] TC_CNT_ONE = 6'h01;
   localparam logic [5:0] TC_CNT_LAST = 6'(TC_CYCLES - 1);
   localparam logic FLAG_RST = 1'b0;

   // Mode select settings, bit3 bit2 bit1
   typedef enum logic [2:0] {
      MODE_EVT_RISE = 3'b000,
      MODE_EVT_FALL = 3'b001,
      MODE_CAP_RR = 3'b010,
      MODE_CAP_FR = 3'b011,
      MODE_PWM_HOLD = 3'b100,
      MODE_PWM_TOGGLE = 3'b101,
      MODE_CAP_RF = 3'b110,
      MODE_CAP_FF = 3'b111
   } drt_mode_e;

   // Software configuration levels
   typedef struct packed {
      drt_mode_e mode;
      logic irq_en_a;
      logic irq_en_b;
      logic idle_en;
   } drt_ctrl_s;

   // Software command pulses
   typedef struct packed {
      logic clr_pend_a;
      logic clr_pend_b;
      logic clr_idle_pend;
      logic run_set;
      logic run_clr;
      logic wr_a;
      logic wr_b;
      logic wr_timer;
   } drt_cmd_s;

   // Flags shown to software
   typedef struct packed {
      logic pend_a;
      logic pend_b;
      logic idle_pend;
      logic run_flag;
   } drt_stat_s;
endpackage : drt_pkg

// File: hw/drt_tick.sv
// Instruction cycle strobe from the system clock
module drt_tick (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   output logic tick_o
);
   // Divider position
   logic [drt_pkg::TC_CNT_W-1:0] cnt;

   // Wrap once per instruction cycle and strobe on the wrap
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= drt_pkg::TC_CNT_RST;
         tick_o <= drt_pkg::FLAG_RST;
      end else if (cnt == drt_pkg::TC_CNT_LAST) begin
         cnt <= drt_pkg::TC_CNT_RST;
         tick_o <= 1'b1;
      end else begin
         cnt <= cnt + drt_pkg::TC_CNT_ONE;
         tick_o <= 1'b0;
      end
   end
endmodule : drt_tick

// File: hw/drt_edge.sv
// Edge finder for a synchronous pin level
module drt_edge (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic level_i,
   output logic rise_o,
   output logic fall_o
);
   // Level seen on the previous clock
   logic prev;

   // Remember the last level
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev <= drt_pkg::FLAG_RST;
      end else begin
         prev <= level_i;
      end
   end

   // Edges are valid in the cycle the new level is seen
   assign rise_o = level_i & ~prev;
   assign fall_o = ~level_i & prev;
endmodule : drt_edge

// File: verif/drt_chk.sv
// Port-level checker for the dual timer block
module drt_chk (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire drt_pkg::drt_ctrl_s ctrl_i,
   input wire drt_pkg::drt_cmd_s cmd_i,
   input wire logic timer_pin_a_i,
   input wire logic timer_pin_b_i,
   input wire logic timer_pin_a_o,
   input wire logic timer_pin_a_oe_o,
   input wire logic [15:0] main_timer_o,
   input wire logic [15:0] reload_capture_reg_a_o,
   input wire logic [15:0] reload_capture_reg_b_o,
   input wire drt_pkg::drt_stat_s status_o,
   input wire logic irq_a_o,
   input wire logic irq_b_o,
   input wire logic idle_irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // High in any of the four capture settings
   logic cap;
   assign cap = ctrl_i.mode[drt_pkg::MSEL_BIT2];
   // Interrupt levels trail their flags and enables by one edge
   a_irq_a_gate: assert property (irq_a_o == $past(ctrl_i.irq_en_a &
      (status_o.pend_a | (cap & status_o.run_flag))))
      else $error("irq a does not follow its flags");
   a_irq_b_gate: assert property (irq_b_o ==
      $past(ctrl_i.irq_en_b & status_o.pend_b))
      else $error("irq b does not follow its flag");
   a_idle_gate: assert property (idle_irq_o ==
      $past(ctrl_i.idle_en & status_o.idle_pend))
      else $error("idle irq does not follow its flag");
   // Pin A is only driven in the pulse settings
   a_oe_pulse_only: assert property ((ctrl_i.mode[2:1] != 2'b10) [*2]
      |-> !timer_pin_a_oe_o)
      else $error("pin a driven outside pulse mode");
   a_hold_no_toggle: assert property ((ctrl_i.mode ==
      drt_pkg::MODE_PWM_HOLD) && $past(ctrl_i.mode == drt_pkg::MODE_PWM_HOLD)
      |-> $stable(timer_pin_a_o))
      else $error("pin a toggled in hold setting");
   // Pending flags drop only when software clears them
   a_pend_a_sticky: assert property ($fell(status_o.pend_a)
      |-> $past(cmd_i.clr_pend_a))
      else $error("pending a dropped by itself");
   a_pend_b_sticky: assert property ($fell(status_o.pend_b)
      |-> $past(cmd_i.clr_pend_b))
      else $error("pending b dropped by itself");
   a_cap_copy_a: assert property ((ctrl_i.mode ==
      drt_pkg::MODE_CAP_RR) && $rose(timer_pin_a_i) |=>
      (reload_capture_reg_a_o == $past(main_timer_o)) && status_o.pend_a)
      else $error("pin a rise did not capture the count");
   a_cap_fall_b: assert property ((ctrl_i.mode ==
      drt_pkg::MODE_CAP_RF) && $fell(timer_pin_b_i) |=>
      reload_capture_reg_b_o == $past(main_timer_o))
      else $error("pin b fall did not capture the count");
   // Capture count only ever moves down by one
   a_cap_down: assert property ($past(cap) && !$past(cmd_i.wr_timer) &&
      $changed(main_timer_o) |-> main_timer_o == $past(main_timer_o) - 16'h1)
      else $error("capture count moved other than down by one");
   a_run_stop: assert property (!$past(cap) && !$past(status_o.run_flag) &&
      !$past(cmd_i.wr_timer) && !$past(cmd_i.run_set) |-> $stable(main_timer_o))
      else $error("stopped timer moved");
   c_pulse_b: cover property (!cap && $rose(status_o.pend_b));
   c_cap_under: cover property (cap && $rose(status_o.run_flag));
   c_idle_tick: cover property ($rose(status_o.idle_pend));
endmodule : drt_chk

bind drt_top drt_chk i_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
   .ctrl_i(ctrl_i), .cmd_i(cmd_i), .timer_pin_a_i(timer_pin_a_i),
   .timer_pin_b_i(timer_pin_b_i), .timer_pin_a_o(timer_pin_a_o),
   .timer_pin_a_oe_o(timer_pin_a_oe_o), .main_timer_o(main_timer_o),
   .reload_capture_reg_a_o(reload_capture_reg_a_o),
   .reload_capture_reg_b_o(reload_capture_reg_b_o), .status_o(status_o),
   .irq_a_o(irq_a_o), .irq_b_o(irq_b_o), .idle_irq_o(idle_irq_o));

// File: verif/drt_pins.sv
// Signal sources and load on the two timer pins
module drt_pins (
   input wire logic sys_clk_i,
   input wire logic src_a_i, // Level the pin A source wants
   input wire logic src_b_i, // Level the pin B source wants
   input wire logic drv_a_i, // Block's pin A value
   input wire logic oe_a_i, // Block drives pin A
   output logic pin_a_o, // Resolved pin A level
   output logic pin_b_o, // Pin B level
   output logic [15:0] tog_cnt_o // Driven pin A changes seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic src_a = 1'b0;
   logic last = 1'b0;
   initial pin_b_o = 1'b0;
   initial tog_cnt_o = 16'h0000;
   // Sources move only just after a clock edge
   always @(posedge sys_clk_i) begin
      src_a <= src_a_i;
      pin_b_o <= src_b_i;
   end
   // Source lets go of pin A while the block drives it
   assign pin_a_o = oe_a_i ? drv_a_i : src_a;
   // Load counts every toggle of the driven pin
   always @(posedge sys_clk_i) begin
      last <= drv_a_i;
      if (oe_a_i && drv_a_i !== last) begin
         tog_cnt_o <= tog_cnt_o + 16'h0001;
      end
   end
endmodule : drt_pins

// File: verif/drt_top_test.sv
// Scenario bench for the dual timer block
module drt_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] C_CA = 8'h80, C_CB = 8'h40, C_CI = 8'h20;
   localparam logic [7:0] C_RS = 8'h10, C_RC = 8'h08, C_WA = 8'h04;
   localparam logic [7:0] C_WB = 8'h02, C_WT = 8'h01;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   drt_pkg::drt_ctrl_s ctrl = '0; // Mode and enables
   drt_pkg::drt_cmd_s cmd = '0; // Command pulses
   logic [15:0] wdata = 16'h0000;
   logic src_a = 1'b0;
   logic src_b = 1'b0;
   logic pin_a, pin_b, pa_o, pa_oe, irq_a, irq_b, idle_irq;
   logic [15:0] tmr, reg_a, reg_b, tog;
   drt_pkg::drt_stat_s st;
   int error_cnt = 0;
   int samples_checked = 0;
   drt_pkg::drt_mode_e caps [4] = '{drt_pkg::MODE_CAP_RR,
      drt_pkg::MODE_CAP_FR, drt_pkg::MODE_CAP_RF, drt_pkg::MODE_CAP_FF};
   // 40 MHz clock
   always #12.5 sys_clk_i = ~sys_clk_i;
   drt_top i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ctrl_i(ctrl),
      .cmd_i(cmd), .wdata_i(wdata), .timer_pin_a_i(pin_a),
      .timer_pin_b_i(pin_b), .timer_pin_a_o(pa_o), .timer_pin_a_oe_o(pa_oe),
      .main_timer_o(tmr), .reload_capture_reg_a_o(reg_a),
      .reload_capture_reg_b_o(reg_b), .status_o(st), .irq_a_o(irq_a),
      .irq_b_o(irq_b), .idle_irq_o(idle_irq));
   drt_pins i_pins (.sys_clk_i(sys_clk_i), .src_a_i(src_a), .src_b_i(src_b),
      .drv_a_i(pa_o), .oe_a_i(pa_oe), .pin_a_o(pin_a), .pin_b_o(pin_b),
      .tog_cnt_o(tog));
   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   task automatic chk1(input string n, input logic e, input logic s);
      samples_checked++;
      if (s !== e) begin
         $display("unexpected %s exp %b got %b", n, e, s);
         error_cnt++;
      end
   endtask : chk1
   task automatic chk16(input string n, input logic [15:0] e,
      input logic [15:0] s);
      samples_checked++;
      if (s !== e) begin
         $display("unexpected %s exp %h got %h", n, e, s);
         error_cnt++;
      end
   endtask : chk16
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : step
   // Outputs are read mid-cycle, clear of the edge
   task automatic look();
      @(negedge sys_clk_i);
   endtask : look
   // One-cycle command pulse with data
   task automatic send(input logic [7:0] c, input logic [15:0] d);
      @(posedge sys_clk_i);
      cmd <= drt_pkg::drt_cmd_s'(c);
      wdata <= d;
      @(posedge sys_clk_i);
      cmd <= '0;
   endtask : send
   // Bounded wait for one status bit
   task automatic wait_st(input int k);
      int i;
      i = 0;
      do begin
         look();
         i++;
      end while (st[k] !== 1'b1 && i < 400);
      if (st[k] !== 1'b1) begin
         $display("unexpected status bit %0d exp 1 got %b", k, st[k]);
         error_cnt++;
         wrap_up();
      end
   endtask : wait_st
   // Move one pin source and let the block see it
   task automatic half(input bit b, input logic v);
      @(posedge sys_clk_i);
      if (b) begin
         src_b <= v;
      end else begin
         src_a <= v;
      end
      step(3);
      look();
   endtask : half
   task automatic test_reset();
      look();
      chk16("status", 16'h0000, 16'(st));
      chk1("irq a", 1'b0, irq_a);
      chk1("pin a oe", 1'b0, pa_oe);
      wait_st(1);
      chk1("idle irq", 1'b0, idle_irq);
      @(posedge sys_clk_i);
      ctrl.idle_en <= 1'b1;
      step(2);
      look();
      chk1("idle irq", 1'b1, idle_irq);
      @(posedge sys_clk_i);
      ctrl.idle_en <= 1'b0;
      step(2);
      look();
      chk1("idle irq", 1'b0, idle_irq);
      send(C_CI, 16'h0000);
      look();
      chk1("idle pend", 1'b0, st.idle_pend);
      $display("test reset done");
   endtask : test_reset
   task automatic test_pulse();
      @(posedge sys_clk_i);
      ctrl.mode <= drt_pkg::MODE_PWM_TOGGLE;
      ctrl.irq_en_a <= 1'b1;
      send(C_WA, 16'h0003);
      send(C_WB, 16'h0001);
      send(C_WT, 16'h0000);
      send(C_RS, 16'h0000);
      wait_st(3);
      chk16("timer", 16'h0003, tmr);
      chk16("reg a", 16'h0003, reg_a);
      chk16("reg b", 16'h0001, reg_b);
      chk1("pin a oe", 1'b1, pa_oe);
      // The load sees the toggle one edge after the underflow
      look();
      chk16("toggles", 16'h0001, tog);
      chk1("irq a", 1'b1, irq_a);
      send(C_CA, 16'h0000);
      wait_st(2);
      chk16("timer", 16'h0001, tmr);
      chk1("pend a", 1'b0, st.pend_a);
      look();
      chk16("toggles", 16'h0002, tog);
      chk1("irq b", 1'b0, irq_b);
      wait_st(3);
      chk16("timer", 16'h0003, tmr);
      send(C_RC | C_CA | C_CB, 16'h0000);
      send(C_WT, 16'h0005);
      step(100);
      look();
      chk16("timer", 16'h0005, tmr);
      chk1("pend a", 1'b0, st.pend_a);
      @(posedge sys_clk_i);
      ctrl.mode <= drt_pkg::MODE_PWM_HOLD;
      send(C_WT, 16'h0000);
      send(C_RS, 16'h0000);
      wait_st(3);
      chk16("toggles", 16'h0003, tog);
      $display("test pulse done");
   endtask : test_pulse
   task automatic test_event();
      @(posedge sys_clk_i);
      ctrl.mode <= drt_pkg::MODE_EVT_RISE;
      ctrl.irq_en_b <= 1'b1;
      send(C_CA | C_CB, 16'h0000);
      send(C_WA, 16'h0002);
      send(C_WT, 16'h0001);
      look();
      chk1("pin a oe", 1'b0, pa_oe);
      half(0, 1'b1);
      chk16("timer", 16'h0000, tmr);
      half(0, 1'b0);
      chk16("timer", 16'h0000, tmr);
      half(0, 1'b1);
      chk16("timer", 16'h0002, tmr);
      chk1("pend a", 1'b1, st.pend_a);
      @(posedge sys_clk_i);
      ctrl.mode <= drt_pkg::MODE_EVT_FALL;
      half(0, 1'b0);
      chk16("timer", 16'h0001, tmr);
      half(0, 1'b1);
      chk16("timer", 16'h0001, tmr);
      half(1, 1'b1);
      chk1("pend b", 1'b1, st.pend_b);
      look();
      chk1("irq b", 1'b1, irq_b);
      half(0, 1'b0);
      half(1, 1'b0);
      $display("test event done");
   endtask : test_event
   task automatic test_capture();
      drt_pkg::drt_mode_e code;
      for (int m = 0; m < 4; m++) begin
         code = caps[m];
         @(posedge sys_clk_i);
         ctrl.mode <= code;
         send(C_CA | C_CB, 16'h0000);
         half(0, 1'b1);
         half(1, 1'b1);
         chk1("pend a", ~code[0], st.pend_a);
         chk1("pend b", ~code[2], st.pend_b);
         send(C_CA | C_CB, 16'h0000);
         half(0, 1'b0);
         half(1, 1'b0);
         chk1("pend a", code[0], st.pend_a);
         chk1("pend b", code[2], st.pend_b);
      end
      send(C_CA | C_CB | C_RC, 16'h0000);
      send(C_WT, 16'h0000);
      wait_st(0);
      chk16("timer", 16'hffff, tmr);
      chk1("pend a", 1'b0, st.pend_a);
      look();
      chk1("irq a", 1'b1, irq_a);
      $display("test capture done");
   endtask : test_capture
   // Main sequence
   initial begin
      step(12);
      rst_n_i <= 1'b1;
      step(4);
      test_reset();
      test_pulse();
      test_event();
      test_capture();
      wrap_up();
   end
endmodule : drt_top_test
